// *** rtl/asfl_pkg.sv ***
// Shared constants and carrier types for the converter serial frame link.
// Assumes a 100 MHz system clock that also serves as the converter master clock.
package asfl_pkg;
	localparam int NCH = 6;
	localparam int FRAME_WORDS = NCH + 2;
	localparam int SAMPLE_W = 24;
	localparam logic [3:0] LAST_WORD = 4'(FRAME_WORDS - 1);

	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_PERIOD_NS = 40000;
	localparam int CONV_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [11:0] CONV_LAST = 12'(CONV_CYCLES - 1);
	localparam int DATA_READY_N_LOW_NS = 200;
	localparam int DATA_READY_N_LOW_CYCLES = (DATA_READY_N_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] DATA_READY_N_LEN = 5'(DATA_READY_N_LOW_CYCLES);

	// Command word: opcode, register address, remainder ignored
	localparam logic [2:0] OP_WRITE = 3'h3;
	localparam logic [2:0] OP_READ = 3'h5;
	localparam int CMD_OP_LSB = 13;
	localparam int CMD_ADDR_LSB = 7;
	localparam logic [5:0] CTRL_ADDR = 6'h01;
	localparam logic [5:0] PAD_ADDR = 6'h3F;

	// Control register layout
	localparam int CHEN_LSB = 0;
	localparam int WLEN_LSB = 8;
	localparam int CRC_EN_BIT = 10;
	localparam logic [15:0] CTRL_MASK = 16'h073F;
	localparam logic [15:0] CTRL_RESET = 16'h013F;
	localparam logic [15:0] PAD_RESET = 16'h0000;
	localparam logic [1:0] WL16 = 2'h0;
	localparam logic [1:0] WL24 = 2'h1;
	localparam logic [1:0] WL32 = 2'h2;

	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;

	typedef logic [SAMPLE_W-1:0] asfl_sample_t;
	typedef asfl_sample_t [NCH-1:0] asfl_frame_t;

	typedef struct packed {
		logic [2:0] op;
		logic [5:0] addr;
		logic [15:0] data;
	} asfl_cmd_t;

	function automatic logic [5:0] asfl_word_bits(input logic [1:0] wlen);
		asfl_word_bits = (wlen == WL16) ? 6'h10 : (wlen == WL24) ? 6'h18 : 6'h20;
	endfunction : asfl_word_bits

	function automatic logic [15:0] asfl_crc_step(input logic [15:0] c, input logic b);
		asfl_crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction : asfl_crc_step
endpackage : asfl_pkg

// *** rtl/asfl_link.sv ***
// Device end of the converter serial frame link: conversion timing, two-frame
// result buffer, data-ready strobe, register writes and the serial shifter.
// Assumes the host owns sclk and cs_n, and sclk only toggles while cs_n is low.
//
// Behaviour
// - Data output is released whenever chip select is high.
// - Conversions run on a common sync-aligned period so one ready suffices.
// - Word length is 24 bits after reset.
// - A 32-bit word length sign-extends results into the upper byte.
// - Frame is status word, channel words, then CRC slot, all same length.
// - Results sit in a two-entry buffer; each completely clocked frame drains one entry.
// - With all channels off, short frames carry single commands.
// - Unread results overflow the buffer; ready then strobes every other period.
`timescale 1ns/10ps
module asfl_link (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	input wire logic sync_reset_n,
	input wire asfl_pkg::asfl_frame_t chan_result,
	output logic data_ready_n
);
	// System domain (clk doubles as the converter master clock)
	logic [1:0] cs_sync_reg;
	logic [1:0] syncn_sync_reg;
	logic cs_dly_reg;
	logic syncn_dly_reg;
	logic [2:0] done_sync_reg;
	logic [2:0] cmd_sync_reg;
	logic [11:0] conv_cnt_reg;
	asfl_pkg::asfl_frame_t fifo_mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic [4:0] data_ready_n_cnt_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] pad_reg;
	asfl_pkg::asfl_cmd_t pend_reg;
	logic pend_valid_reg;
	logic ovf_flag_reg;
	logic resp_arm_reg;
	logic resp_valid_reg;
	logic [15:0] resp_reg;
	logic [15:0] first_word_reg;
	// Link domain
	logic [4:0] bit_cnt_reg;
	logic [3:0] word_cnt_reg;
	logic [15:0] crc_reg;
	logic [15:0] rx_sh_reg;
	logic [15:0] cmd_word_reg;
	logic done_seen_reg;
	logic started_reg;
	logic [15:0] lctrl_reg;
	logic [15:0] lfirst_reg;
	asfl_pkg::asfl_cmd_t hold_reg;
	logic cmd_tgl_reg;
	logic done_tgl_reg;

	logic cs_rise, sync_fall, done_ev, cmd_ev, conv_ev;
	logic push, pop, in_ready, out_valid, ovf, data_ready_n_fire;
	logic wr_valid;
	logic rd_hit;
	asfl_pkg::asfl_cmd_t wr_cmd;

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_sync_reg <= 2'h3;
			syncn_sync_reg <= 2'h3;
			cs_dly_reg <= 1'b1;
			syncn_dly_reg <= 1'b1;
		end else begin
			cs_sync_reg <= {cs_sync_reg[0], cs_n};
			syncn_sync_reg <= {syncn_sync_reg[0], sync_reset_n};
			cs_dly_reg <= cs_sync_reg[1];
			syncn_dly_reg <= syncn_sync_reg[1];
		end
	end

	// Toggle events from the link domain
	always_ff @(posedge clk) begin
		if (rst) begin
			done_sync_reg <= 3'h0;
			cmd_sync_reg <= 3'h0;
		end else begin
			done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
			cmd_sync_reg <= {cmd_sync_reg[1:0], cmd_tgl_reg};
		end
	end

	assign cs_rise = cs_sync_reg[1] & ~cs_dly_reg;
	assign sync_fall = ~syncn_sync_reg[1] & syncn_dly_reg;
	assign done_ev = done_sync_reg[2] ^ done_sync_reg[1];
	assign cmd_ev = cmd_sync_reg[2] ^ cmd_sync_reg[1];

	// Conversion period; a sync strobe restarts it so grouped devices align
	always_ff @(posedge clk) begin
		if (rst || sync_fall || conv_cnt_reg == asfl_pkg::CONV_LAST) begin
			conv_cnt_reg <= 12'h000;
		end else begin
			conv_cnt_reg <= conv_cnt_reg + 12'h001;
		end
	end
	assign conv_ev = (conv_cnt_reg == asfl_pkg::CONV_LAST);

	// Two-entry result buffer; drained only by a completely clocked frame
	assign push = conv_ev;
	assign in_ready = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign pop = out_valid & done_ev;
	assign ovf = push & ~in_ready & ~pop;
	assign data_ready_n_fire = push & ((cnt_reg == 2'h0) | ovf);

	always_ff @(posedge clk) begin
		if (push) begin
			fifo_mem_reg[wr_ptr_reg] <= chan_result;
		end
	end

	// On overflow both stale frames are dropped, which halves the ready rate
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (ovf) begin
				rd_ptr_reg <= wr_ptr_reg;
			end else if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if (ovf) begin
				cnt_reg <= 2'h1;
			end else if (push && !pop) begin
				cnt_reg <= cnt_reg + 2'h1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_flag_reg <= 1'b0;
		end else if (ovf) begin
			ovf_flag_reg <= 1'b1;
		end else if (done_ev) begin
			ovf_flag_reg <= 1'b0;
		end
	end

	// Active-low ready strobe of fixed length
	always_ff @(posedge clk) begin
		if (rst) begin
			data_ready_n_cnt_reg <= 5'h00;
			data_ready_n <= 1'b1;
		end else if (data_ready_n_fire) begin
			data_ready_n_cnt_reg <= asfl_pkg::DATA_READY_N_LEN;
			data_ready_n <= 1'b0;
		end else if (data_ready_n_cnt_reg != 5'h00) begin
			data_ready_n_cnt_reg <= data_ready_n_cnt_reg - 5'h01;
			data_ready_n <= (data_ready_n_cnt_reg == 5'h01);
		end
	end

	// Commands apply at once with channels off, otherwise only on a full frame
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_valid_reg <= 1'b0;
			pend_reg <= '0;
		end else if (cmd_ev && ctrl_reg[asfl_pkg::CHEN_LSB +: asfl_pkg::NCH] != '0) begin
			pend_valid_reg <= 1'b1;
			pend_reg <= hold_reg;
		end else if (done_ev || cs_rise) begin
			pend_valid_reg <= 1'b0;
		end
	end

	always_comb begin
		wr_valid = 1'b0;
		wr_cmd = pend_reg;
		if (cmd_ev && ctrl_reg[asfl_pkg::CHEN_LSB +: asfl_pkg::NCH] == '0) begin
			wr_valid = 1'b1;
			wr_cmd = hold_reg;
		end else if (done_ev && pend_valid_reg) begin
			wr_valid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= asfl_pkg::CTRL_RESET;
			pad_reg <= asfl_pkg::PAD_RESET;
		end else if (wr_valid && wr_cmd.op == asfl_pkg::OP_WRITE) begin
			if (wr_cmd.addr == asfl_pkg::CTRL_ADDR) begin
				ctrl_reg <= wr_cmd.data & asfl_pkg::CTRL_MASK;
			end else if (wr_cmd.addr == asfl_pkg::PAD_ADDR) begin
				pad_reg <= wr_cmd.data;
			end
		end
	end

	// A read answer replaces the status word of the following frame. The frame
	// end and the chip select rise may land in one cycle, so neither may be lost.
	assign rd_hit = wr_valid && (wr_cmd.op == asfl_pkg::OP_READ);

	always_ff @(posedge clk) begin
		if (rst) begin
			resp_arm_reg <= 1'b0;
			resp_valid_reg <= 1'b0;
			resp_reg <= 16'h0000;
		end else begin
			if (rd_hit) begin
				resp_reg <= (wr_cmd.addr == asfl_pkg::CTRL_ADDR) ? ctrl_reg :
					(wr_cmd.addr == asfl_pkg::PAD_ADDR) ? pad_reg : 16'h0000;
			end
			if (cs_rise) begin
				resp_valid_reg <= resp_arm_reg | rd_hit;
				resp_arm_reg <= 1'b0;
			end else if (rd_hit) begin
				resp_arm_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			first_word_reg <= 16'h0000;
		end else begin
			first_word_reg <= resp_valid_reg ? resp_reg :
				{ovf_flag_reg, cnt_reg, 2'h0, ctrl_reg[10:0]};
		end
	end

	// Link side. Configuration and status are taken once at the first edge of a
	// frame; a change landing on that very edge may tear, so hosts avoid it.
	logic [31:0] word_al;
	logic [5:0] wbits;
	logic last_bit;
	logic [2:0] ch_idx;
	asfl_pkg::asfl_sample_t smp;

	assign wbits = asfl_pkg::asfl_word_bits(lctrl_reg[asfl_pkg::WLEN_LSB +: 2]);
	assign last_bit = ({1'b0, bit_cnt_reg} == wbits - 6'h01);
	assign ch_idx = 3'(word_cnt_reg - 4'h1);

	always_comb begin
		smp = fifo_mem_reg[rd_ptr_reg][ch_idx];
		word_al = 32'h0000_0000;
		if (word_cnt_reg == 4'h0) begin
			word_al = {lfirst_reg, 16'h0000};
		end else if (word_cnt_reg == asfl_pkg::LAST_WORD) begin
			if (lctrl_reg[asfl_pkg::CRC_EN_BIT]) begin
				word_al = {crc_reg, 16'h0000};
			end
		end else if (lctrl_reg[asfl_pkg::CHEN_LSB + 32'(ch_idx)]) begin
			if (lctrl_reg[asfl_pkg::WLEN_LSB +: 2] == asfl_pkg::WL32) begin
				word_al = {{8{smp[23]}}, smp};
			end else begin
				word_al = {smp, 8'h00};
			end
		end
	end

	// Drive on rising sclk; chip select high clears the driver at once
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			dout <= 1'b0;
			dout_oe <= 1'b0;
			started_reg <= 1'b0;
			lctrl_reg <= asfl_pkg::CTRL_RESET;
			lfirst_reg <= 16'h0000;
		end else begin
			dout_oe <= 1'b1;
			started_reg <= 1'b1;
			if (!started_reg) begin
				lctrl_reg <= ctrl_reg;
				lfirst_reg <= first_word_reg;
				dout <= first_word_reg[15];
			end else begin
				dout <= word_al[5'h1F - bit_cnt_reg];
			end
		end
	end

	// Sample on falling sclk; counters live only while the frame is open
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_reg <= 5'h00;
			word_cnt_reg <= 4'h0;
			crc_reg <= asfl_pkg::CRC_INIT;
			rx_sh_reg <= 16'h0000;
			cmd_word_reg <= 16'h0000;
			done_seen_reg <= 1'b0;
		end else begin
			rx_sh_reg <= {rx_sh_reg[14:0], din};
			if (word_cnt_reg != asfl_pkg::LAST_WORD) begin
				crc_reg <= asfl_pkg::asfl_crc_step(crc_reg, dout);
			end
			if (word_cnt_reg == 4'h0 && bit_cnt_reg == 5'h0F) begin
				cmd_word_reg <= {rx_sh_reg[14:0], din};
			end
			if (last_bit) begin
				bit_cnt_reg <= 5'h00;
				if (word_cnt_reg != asfl_pkg::LAST_WORD) begin
					word_cnt_reg <= word_cnt_reg + 4'h1;
				end else begin
					done_seen_reg <= 1'b1;
				end
			end else begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(negedge sclk) begin
		if (word_cnt_reg == 4'h1 && bit_cnt_reg == 5'h0F) begin
			hold_reg <= '{op: cmd_word_reg[asfl_pkg::CMD_OP_LSB +: 3],
				addr: cmd_word_reg[asfl_pkg::CMD_ADDR_LSB +: 6],
				data: {rx_sh_reg[14:0], din}};
		end
	end

	// Event toggles must outlive the frame, so only system reset clears them
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			cmd_tgl_reg <= 1'b0;
			done_tgl_reg <= 1'b0;
		end else if (!cs_n) begin
			if (word_cnt_reg == 4'h1 && bit_cnt_reg == 5'h0F &&
				(cmd_word_reg[15:13] == asfl_pkg::OP_WRITE ||
				cmd_word_reg[15:13] == asfl_pkg::OP_READ)) begin
				cmd_tgl_reg <= ~cmd_tgl_reg;
			end
			if (last_bit && word_cnt_reg == asfl_pkg::LAST_WORD && !done_seen_reg) begin
				done_tgl_reg <= ~done_tgl_reg;
			end
		end
	end

	AST_DOUT_RELEASED: assert property (@(posedge clk) disable iff (rst)
		cs_n |-> !dout_oe) else $error("data output driven with chip select high");
	AST_RESET_WORD24: assert property (@(posedge clk)
		$fell(rst) |-> ctrl_reg[9:8] == 2'h1 ##1 ctrl_reg[9:8] == 2'h1)
		else $error("word length not 24 after reset");
	AST_SYNC_RESTART: assert property (@(posedge clk) disable iff (rst)
		sync_fall |=> conv_cnt_reg == 12'h000 ##1 conv_cnt_reg == 12'h001)
		else $error("sync strobe did not restart conversion timing");
	AST_DATA_READY_N_WIDTH: assert property (@(posedge clk) disable iff (rst)
		$fell(data_ready_n) |-> ##19 !data_ready_n ##1 data_ready_n)
		else $error("ready strobe length wrong");
	AST_OVERFLOW_ONE: assert property (@(posedge clk) disable iff (rst)
		(push && cnt_reg == 2'h2 && !done_ev) |=> cnt_reg == 2'h1 && !data_ready_n)
		else $error("overflow did not leave one fresh frame");
	AST_FILL_EMPTY: assert property (@(posedge clk) disable iff (rst)
		(push && cnt_reg == 2'h0) |=> cnt_reg == 2'h1 && $fell(data_ready_n))
		else $error("push into empty buffer mishandled");
	AST_SHORT_WRITE: assert property (@(posedge clk) disable iff (rst)
		(cmd_ev && ctrl_reg[5:0] == 6'h00 && hold_reg.op == 3'h3 && hold_reg.addr == 6'h3F)
		|=> pad_reg == $past(hold_reg.data)) else $error("short frame write lost");
	AST_POP_ON_FRAME: assert property (@(posedge clk) disable iff (rst)
		(rd_ptr_reg != $past(rd_ptr_reg)) |-> $past(done_ev) || $past(ovf))
		else $error("buffer drained without a full frame");
	AST_SIGN_EXT: assert property (@(posedge sclk) disable iff (cs_n)
		(lctrl_reg[9:8] == 2'h2 && word_cnt_reg != 4'h0 && word_cnt_reg != 4'h7)
		|-> word_al[31:24] == {8{word_al[23]}}) else $error("32-bit word not sign-extended");
	AST_FRAME_END: assert property (@(negedge sclk) disable iff (cs_n)
		(last_bit && !done_seen_reg && word_cnt_reg != 4'h7) |=> !done_seen_reg)
		else $error("frame ended before the CRC slot");
endmodule : asfl_link

// *** tb/asfl_host.sv ***
// Host-side serial bus master model for the converter frame link.
// Assumes one converter on the bus; sclk rests low and only runs inside frames.
`timescale 1ns/10ps
module asfl_host (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic go,
	input wire logic [5:0] nbits,
	input wire logic [15:0] tx0,
	input wire logic [15:0] tx1,
	output logic done,
	output logic rx_valid,
	output logic [31:0] rx_word
);
	logic [31:0] word;
	logic [31:0] rx;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		done = 1'b0;
		rx_valid = 1'b0;
		rx_word = 32'h0000_0000;
		forever begin
			@(posedge go);
			cs_n = 1'b0;
			#4;
			for (int w = 0; w < asfl_pkg::FRAME_WORDS; w++) begin
				word = (w == 0) ? {tx0, 16'h0000} : (w == 1) ? {tx1, 16'h0000} : 32'h0000_0000;
				rx = 32'h0000_0000;
				for (int b = 0; b < int'(nbits); b++) begin
					sclk = 1'b1;
					din = word[31-b];
					#3;
					sclk = 1'b0;
					rx = {rx[30:0], dout};
					#3;
				end
				// The CRC slot is clocked but never reported
				if (w < asfl_pkg::FRAME_WORDS - 1) begin
					rx_word = rx;
					rx_valid = 1'b1;
					#1;
					rx_valid = 1'b0;
				end
			end
			#2;
			cs_n = 1'b1;
			// Released line must not keep looking valid
			din = ~din;
			done = 1'b1;
			@(negedge go);
			done = 1'b0;
		end
	end
endmodule : asfl_host

// *** tb/asfl_link_bench.sv ***
// Self-checking bench for the converter frame link with a host model on the link.
// Assumes package constants: 6 channels, 4000-cycle conversions, 20-cycle ready strobe.
`timescale 1ns/10ps
module asfl_link_bench;
	logic clk, rst, sclk, cs_n, din, dout, dout_oe, sync_reset_n, data_ready_n;
	logic go, done, rx_valid, prev;
	logic [5:0] nbits;
	logic [15:0] tx0, tx1;
	logic [31:0] rx_word;
	logic [31:0] exp_q[$];
	asfl_pkg::asfl_frame_t chan_result;
	int miscompares, total_checks, seed, n;

	asfl_link dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .sync_reset_n(sync_reset_n), .chan_result(chan_result),
		.data_ready_n(data_ready_n));
	asfl_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .go(go), .nbits(nbits),
		.tx0(tx0), .tx1(tx1), .done(done), .rx_valid(rx_valid), .rx_word(rx_word));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task test_done;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	function automatic asfl_pkg::asfl_frame_t rand_frame();
		asfl_pkg::asfl_frame_t f;
		for (int i = 0; i < asfl_pkg::NCH; i++) f[i] = 24'($random(seed));
		return f;
	endfunction : rand_frame

	function automatic logic [31:0] exp_word(input logic [5:0] nb, input logic [23:0] s);
		return (nb == 6'h20) ? {{8{s[23]}}, s} : {8'h00, s};
	endfunction : exp_word

	// Host starts reads only after a ready fall, so waiting here keeps that order
	task wait_ready(output int cyc);
		cyc = 0;
		while (data_ready_n !== 1'b0) begin
			@(negedge clk);
			cyc++;
			if (cyc > 5000) begin
				miscompares++;
				test_done();
			end
		end
	endtask : wait_ready

	task frame(input logic [5:0] nb, input logic en, input logic [15:0] c0, input logic [15:0] c1,
		input logic [15:0] st);
		int i;
		repeat (5) @(negedge clk);
		cmp("dout_oe idle", 32'h0000_0000, {31'h0, dout_oe});
		exp_q.push_back(nb == 6'h20 ? {st, 16'h0000} : {8'h00, st, 8'h00});
		for (i = 0; i < asfl_pkg::NCH; i++)
			exp_q.push_back(en ? exp_word(nb, chan_result[i]) : 32'h0000_0000);
		nbits = nb;
		tx0 = c0;
		tx1 = c1;
		go = 1'b1;
		i = 0;
		while (done !== 1'b1) begin
			@(negedge clk);
			i++;
			if (i > 1000) begin
				miscompares++;
				test_done();
			end
		end
		go = 1'b0;
		@(negedge clk);
		chan_result = rand_frame();
	endtask : frame

	always @(posedge rx_valid) begin
		cmp("dout_oe busy", 32'h0000_0001, {31'h0, dout_oe});
		if (exp_q.size() == 0)
			cmp("spare word", 32'h0000_0000, 32'h0000_0001);
		else
			cmp("frame word", exp_q.pop_front(), rx_word);
	end

	initial begin
		#1000000;
		miscompares++;
		test_done();
	end

	initial begin
		seed = 26015;
		rst = 1'b1;
		sync_reset_n = 1'b1;
		go = 1'b0;
		nbits = 6'h18;
		tx0 = 16'h0000;
		tx1 = 16'h0000;
		chan_result = rand_frame();
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		sync_reset_n = 1'b0;
		repeat (2) @(negedge clk);
		sync_reset_n = 1'b1;
		wait_ready(n);
		cmp("sync to ready", 32'h0000_0001, {31'h0, n > 3990 && n < 4015});
		n = 0;
		while (data_ready_n === 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		cmp("ready low", 32'(asfl_pkg::DATA_READY_N_LOW_CYCLES), 32'(n));
		frame(6'h18, 1'b1, 16'h0000, 16'h0000, 16'h213F);
		wait_ready(n);
		frame(6'h18, 1'b1, {asfl_pkg::OP_WRITE, asfl_pkg::CTRL_ADDR, 7'h00}, 16'h023F,
			16'h213F);
		wait_ready(n);
		// Unknown opcode aimed at the control register must leave 32-bit words in place
		frame(6'h20, 1'b1, {3'h7, asfl_pkg::CTRL_ADDR, 7'h00}, 16'h0000, 16'h223F);
		wait_ready(n);
		frame(6'h20, 1'b1, 16'h0000, 16'h0000, 16'h223F);
		n = 0;
		for (int i = 0; i < 12000; i++) begin
			prev = data_ready_n;
			@(negedge clk);
			if (prev === 1'b1 && data_ready_n === 1'b0) n++;
		end
		cmp("ready falls unread", 32'h0000_0002, 32'(n));
		frame(6'h20, 1'b1, 16'h0000, 16'h0000, 16'hA23F);
		wait_ready(n);
		// Read answer shows up as the status word of the next frame
		frame(6'h20, 1'b1, {asfl_pkg::OP_READ, asfl_pkg::CTRL_ADDR, 7'h00}, 16'h0000,
			16'h223F);
		wait_ready(n);
		frame(6'h20, 1'b1, 16'h0000, 16'h0000, 16'h023F);
		wait_ready(n);
		frame(6'h20, 1'b1, {asfl_pkg::OP_WRITE, asfl_pkg::CTRL_ADDR, 7'h00}, 16'h0200,
			16'h223F);
		wait_ready(n);
		// All channels off: command applies at once, channel words read zero
		frame(6'h20, 1'b0, {asfl_pkg::OP_WRITE, asfl_pkg::PAD_ADDR, 7'h00}, 16'h5A5A,
			16'h2200);
		test_done();
	end
endmodule : asfl_link_bench
